// ==== shared/wdl_pkg.sv ====
// package: register map, field layout, reset values and helpers of the watchdog
package wdl_pkg;

  // ==========================================================
  // counter geometry
  localparam int unsigned WDL_XTAL_HZ        = 32768;
  localparam int unsigned WDL_CNT_W          = 16;
  localparam logic [4:0]  WDL_PRE_BASE_SHIFT = 5'd9;
  localparam logic [3:0]  WDL_PRE_LONGEST    = 4'h7;
  localparam logic [3:0]  WDL_PRE_AUTO_RST   = 4'h8;
  localparam logic [3:0]  WDL_PRE_DL_RST     = 4'h9;

  // ==========================================================
  // register indices (word index, byte address is index times four)
  localparam logic [13:0] WDL_IDX_CTRL       = 14'h00C0;
  localparam logic [13:0] WDL_IDX_KEY        = 14'h00BB;
  localparam logic [13:0] WDL_IDX_CNT        = 14'h00C8;
  localparam logic [13:0] WDL_IDX_PROT_FIRST = 14'h3FFA;
  localparam logic [13:0] WDL_IDX_PROT_LAST  = 14'h3FFF;

  // ==========================================================
  // control register fields
  localparam int unsigned WDL_CTRL_PRE_LSB    = 4;
  localparam int unsigned WDL_CTRL_IRQSEL_BIT = 3;
  localparam int unsigned WDL_CTRL_FLAG_BIT   = 2;
  localparam int unsigned WDL_CTRL_RUN_BIT    = 1;
  localparam int unsigned WDL_CTRL_UNLOCK_BIT = 0;
  localparam int unsigned WDL_LOCK_BIT        = 7;
  localparam int unsigned WDL_PROT_BYTES      = 6;

  // ==========================================================
  // reset values
  localparam logic [3:0] WDL_RST_PRE    = WDL_PRE_LONGEST;
  localparam logic       WDL_RST_RUN    = 1'b1;
  localparam logic       WDL_RST_IRQSEL = 1'b0;
  localparam logic       WDL_RST_FLAG   = 1'b0;
  localparam logic       WDL_RST_UNLOCK = 1'b0;
  localparam logic [7:0] WDL_RST_PROT   = 8'hFF;
  localparam logic [7:0] WDL_RST_KEY    = 8'h00;

  // ==========================================================
  // bus answers
  localparam logic [1:0] WDL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] WDL_RESP_SLVERR = 2'h2;
  localparam logic [1:0] WDL_RESP_DECERR = 2'h3;

  typedef enum logic [4:0] {
    WDL_RG_NONE = 5'h01,
    WDL_RG_CTRL = 5'h02,
    WDL_RG_KEY  = 5'h04,
    WDL_RG_CNT  = 5'h08,
    WDL_RG_PROT = 5'h10
  } wdl_region_e;

  // ==========================================================
  // helpers
  function automatic wdl_region_e wdl_decode(input logic [15:0] addr);
    logic [13:0] idx;
    idx = addr[15:2];
    if (addr[1:0] != 2'h0) begin
      return WDL_RG_NONE;
    end else if (idx == WDL_IDX_CTRL) begin
      return WDL_RG_CTRL;
    end else if (idx == WDL_IDX_KEY) begin
      return WDL_RG_KEY;
    end else if (idx == WDL_IDX_CNT) begin
      return WDL_RG_CNT;
    end else if (idx >= WDL_IDX_PROT_FIRST && idx <= WDL_IDX_PROT_LAST) begin
      return WDL_RG_PROT;
    end else begin
      return WDL_RG_NONE;
    end
  endfunction

  // count value reached just before the 2^(pre+9)-th crystal edge
  function automatic logic [15:0] wdl_tmo_mask(input logic [3:0] pre);
    logic [16:0] m;
    m = (17'h00001 << ({1'b0, pre} + WDL_PRE_BASE_SHIFT)) - 17'h00001;
    return m[15:0];
  endfunction

endpackage

// ==== shared/wdl_tick_if.sv ====
// interface: control and status between register side and crystal counter
interface wdl_tick_if;
  logic        xtal;
  logic        run;
  logic        clear;
  logic [3:0]  pre;
  logic        expire;
  logic [15:0] count;

  modport ctl (
    output xtal,
    output run,
    output clear,
    output pre,
    input  expire,
    input  count
  );

  modport cnt (
    input  xtal,
    input  run,
    input  clear,
    input  pre,
    output expire,
    output count
  );
endinterface

// ==== design/wdl_counter.sv ====
// module: 16-bit watchdog counter stepped by crystal edges
module wdl_counter
  import wdl_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  wdl_tick_if.cnt   t
);

  typedef struct packed {
    logic        xtal_prev;
    logic [15:0] cnt;
    logic        expire;
  } wdl_cnt_s;

  wdl_cnt_s q;
  wdl_cnt_s d;

  // ==========================================================
  // next state
  always_comb begin
    d           = q;
    d.xtal_prev = t.xtal;
    d.expire    = 1'b0;
    if (t.clear || !t.run) begin
      d.cnt = '0;
    end else if (t.xtal && !q.xtal_prev) begin
      if (t.pre <= WDL_PRE_LONGEST && q.cnt == wdl_tmo_mask(t.pre)) begin
        d.cnt    = '0;
        d.expire = 1'b1;
      end else begin
        // invalid codes just wrap, never expire
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.expire = q.expire;
  assign t.count  = q.cnt;

endmodule

// ==== design/wdl_top.sv ====
// module: watchdog with unlock sequence and flash lock, AXI4-Lite registers
// What this block does
// - out of reset the dog runs with prescale 7, resetting after 2 s.
// - clearing the run bit stops the watchdog.
// - the counter advances on the 32.768 kHz crystal, not the core clock.
// - a 16-bit counter expires after 2^prescale times 2^9 crystal periods.
// - codes 0 to 7 give 15.6 ms up to 2 s via higher counter bits.
// - code 8 resets at once, code 9 asks a download reset, 10-15 unused.
// - at expiry a clear irq select resets the system, a set one interrupts.
// - every expiry sets the sticky flag, cleared by writing 0 or reset pin.
// - each write of run=1 enables the dog and zeroes its counter.
// - control takes a write only right after a write that set unlock.
// - lock bit clear forces irq select 0 and run 1, ignoring writes.
// - under the lock the prescale stays writable by the sequence.
// - the protection byte doubles as the flash key value.
// - protection bytes change only when the stored key equals the key reg.
module wdl_top
  import wdl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        crystal_in_pin,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sys_reset_req,
  output logic             download_reset_req,
  output logic             wdt_irq
);

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    WDL_ST_IDLE  = 3'b001,
    WDL_ST_WRESP = 3'b010,
    WDL_ST_RRESP = 3'b100
  } wdl_st_e;

  typedef struct packed {
    wdl_st_e          st;
    logic             aw_got;
    logic [15:0]      awaddr;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             ar_got;
    logic [15:0]      araddr;
    logic             awready;
    logic             wready;
    logic             arready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [3:0]       pre;
    logic             irq_sel;
    logic             flag;
    logic             run;
    logic             unlock;
    logic             clr_cnt;
    logic [7:0]       key_reg;
    logic [5:0][7:0]  prot;
    logic             sys_rst;
    logic             dl_rst;
    logic             irq;
  } wdl_top_s;

  wdl_top_s q;
  wdl_top_s d;

  wdl_tick_if t ();

  wdl_counter i_wdl_counter (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .t        (t)
  );

  assign t.xtal  = crystal_in_pin;
  assign t.run   = q.run;
  assign t.clear = q.clr_cnt;
  assign t.pre   = q.pre;

  // ==========================================================
  // read mux
  // slot of a protection byte from its byte address
  function automatic logic [2:0] prot_slot(input logic [15:0] addr);
    logic [13:0] off;
    off = addr[15:2] - WDL_IDX_PROT_FIRST;
    return off[2:0];
  endfunction

  // control byte as software reads it back
  function automatic logic [7:0] ctrl_image(input wdl_top_s s);
    logic [7:0] v;
    v                        = 8'h00;
    v[WDL_CTRL_PRE_LSB +: 4] = s.pre;
    v[WDL_CTRL_IRQSEL_BIT]   = s.irq_sel;
    v[WDL_CTRL_FLAG_BIT]     = s.flag;
    v[WDL_CTRL_RUN_BIT]      = s.run;
    v[WDL_CTRL_UNLOCK_BIT]   = s.unlock;
    return v;
  endfunction

  function automatic logic [31:0] rd_value(input wdl_top_s s,
                                           input logic [15:0] addr,
                                           input logic [15:0] cnt);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (wdl_decode(addr))
      WDL_RG_CTRL: v[7:0]  = ctrl_image(s);
      WDL_RG_KEY:  v[7:0]  = s.key_reg;
      WDL_RG_CNT:  v[15:0] = cnt;
      WDL_RG_PROT: v[7:0]  = s.prot[prot_slot(addr)];
      default:     v       = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    wdl_region_e rg;
    logic        locked;
    logic        flag_clr;
    logic        ctrl_ok;
    logic [2:0]  pi;
    logic        expired;
    rg       = WDL_RG_NONE;
    locked   = 1'b0;
    flag_clr = 1'b0;
    ctrl_ok  = 1'b0;
    pi       = 3'h0;
    expired  = 1'b0;

    d         = q;
    d.sys_rst = 1'b0;
    d.dl_rst  = 1'b0;
    d.irq     = 1'b0;
    d.clr_cnt = 1'b0;

    // lock bit is bit 7 of the key byte
    locked = !q.prot[0][WDL_LOCK_BIT];

    case (q.st)
      WDL_ST_IDLE: begin
        if (s_axi_awvalid && q.awready) begin
          d.aw_got = 1'b1;
          d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
          d.w_got = 1'b1;
          d.wdata = s_axi_wdata;
          d.wstrb = s_axi_wstrb;
        end
        if (s_axi_arvalid && q.arready) begin
          d.ar_got = 1'b1;
          d.araddr = s_axi_araddr;
        end

        if (d.aw_got && d.w_got) begin
          rg       = wdl_decode(d.awaddr);
          d.aw_got = 1'b0;
          d.w_got  = 1'b0;
          d.bvalid = 1'b1;
          d.bresp  = WDL_RESP_OKAY;
          d.st     = WDL_ST_WRESP;
          d.unlock = 1'b0;
          ctrl_ok  = (rg == WDL_RG_CTRL) && d.wstrb[0];
          if (rg == WDL_RG_NONE) begin
            d.bresp = WDL_RESP_DECERR;
          end else if (ctrl_ok && q.unlock) begin
            // second write of the pair lands
            d.pre = d.wdata[WDL_CTRL_PRE_LSB +: 4];
            if (!locked) begin
              d.irq_sel = d.wdata[WDL_CTRL_IRQSEL_BIT];
              // run bit cleared stops the dog
              d.run     = d.wdata[WDL_CTRL_RUN_BIT];
            end
            flag_clr = !d.wdata[WDL_CTRL_FLAG_BIT];
            if (d.wdata[WDL_CTRL_RUN_BIT]) begin
              d.clr_cnt = 1'b1;
            end
            if (d.pre == WDL_PRE_AUTO_RST) begin
              d.sys_rst = 1'b1;
            end else if (d.pre == WDL_PRE_DL_RST) begin
              d.dl_rst = 1'b1;
            end
          end else if (ctrl_ok) begin
            d.unlock = d.wdata[WDL_CTRL_UNLOCK_BIT];
          end else if (rg == WDL_RG_KEY) begin
            if (d.wstrb[0]) begin
              d.key_reg = d.wdata[7:0];
            end
          end else if (rg == WDL_RG_PROT) begin
            pi = prot_slot(d.awaddr);
            // key must match the stored byte
            if (q.prot[0] == q.key_reg) begin
              if (d.wstrb[0]) begin
                d.prot[pi] = d.wdata[7:0];
              end
            end else begin
              d.bresp = WDL_RESP_SLVERR;
            end
          end
          // counter register is read only, write is dropped
        end else if (d.ar_got) begin
          d.ar_got = 1'b0;
          d.rvalid = 1'b1;
          // count is taken when the read is served: at the address handshake, or later if a write goes first
          d.rdata  = rd_value(q, d.araddr, t.count);
          d.rresp  = (wdl_decode(d.araddr) == WDL_RG_NONE) ?
                     WDL_RESP_DECERR : WDL_RESP_OKAY;
          d.st     = WDL_ST_RRESP;
        end
      end
      WDL_ST_WRESP: begin
        if (s_axi_bready) begin
          d.bvalid = 1'b0;
          d.st     = WDL_ST_IDLE;
        end
      end
      WDL_ST_RRESP: begin
        if (s_axi_rready) begin
          d.rvalid = 1'b0;
          d.st     = WDL_ST_IDLE;
        end
      end
      default: begin
        d.st = WDL_ST_IDLE;
      end
    endcase

    // readies only while idle and the slot is free
    d.awready = (d.st == WDL_ST_IDLE) && !d.aw_got;
    d.wready  = (d.st == WDL_ST_IDLE) && !d.w_got;
    d.arready = (d.st == WDL_ST_IDLE) && !d.ar_got;

    // lock forces run on and reset mode
    if (!d.prot[0][WDL_LOCK_BIT]) begin
      d.run     = 1'b1;
      d.irq_sel = 1'b0;
    end

    expired = t.expire && q.run;
    if (expired) begin
      if (q.irq_sel) begin
        d.irq = 1'b1;
      end else begin
        d.sys_rst = 1'b1;
      end
    end

    // immediate reset code outranks a same-cycle interrupt
    if (d.sys_rst) begin
      d.irq = 1'b0;
    end

    // set wins over a same-cycle clear
    d.flag = (q.flag && !flag_clr) || expired;
  end

  // ==========================================================
  // registers
  // the flag only resets on rst_n: the system reset this block
  // requests must not be wired back to rst_n, or the flag is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.st      <= WDL_ST_IDLE;
      q.aw_got  <= 1'b0;
      q.awaddr  <= 16'h0000;
      q.w_got   <= 1'b0;
      q.wdata   <= 32'h0000_0000;
      q.wstrb   <= 4'h0;
      q.ar_got  <= 1'b0;
      q.araddr  <= 16'h0000;
      q.awready <= 1'b0;
      q.wready  <= 1'b0;
      q.arready <= 1'b0;
      q.bvalid  <= 1'b0;
      q.bresp   <= WDL_RESP_OKAY;
      q.rvalid  <= 1'b0;
      q.rresp   <= WDL_RESP_OKAY;
      q.rdata   <= 32'h0000_0000;
      q.pre     <= WDL_RST_PRE;
      q.run     <= WDL_RST_RUN;
      q.irq_sel <= WDL_RST_IRQSEL;
      q.flag    <= WDL_RST_FLAG;
      q.unlock  <= WDL_RST_UNLOCK;
      q.clr_cnt <= 1'b0;
      q.key_reg <= WDL_RST_KEY;
      // flash contents modelled as flip-flops, blank after reset
      q.prot    <= {WDL_PROT_BYTES{WDL_RST_PROT}};
      q.sys_rst <= 1'b0;
      q.dl_rst  <= 1'b0;
      q.irq     <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_arready      = q.arready;
  assign s_axi_rdata        = q.rdata;
  assign s_axi_rresp        = q.rresp;
  assign s_axi_rvalid       = q.rvalid;
  assign sys_reset_req      = q.sys_rst;
  assign download_reset_req = q.dl_rst;
  assign wdt_irq            = q.irq;

endmodule

// ==== bench/wdl_top_monitor.sv ====
// checker: handshake and event-pulse properties at the watchdog ports
module wdl_top_monitor
  import wdl_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        crystal_in_pin,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sys_reset_req,
  input wire logic        download_reset_req,
  input wire logic        wdt_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // bus answers
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready while answer pending");
  misalign_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == WDL_RESP_DECERR)
    else $error("misaligned read accepted");

  // ==========================================================
  // timeout and reset-code events
  event_excl_a: assert property (!(sys_reset_req && wdt_irq))
    else $error("reset and interrupt together");
  download_cause_a: assert property (download_reset_req |->
    ($past(s_axi_bvalid) || s_axi_bvalid) ##1 !download_reset_req)
    else $error("download reset without write");
  irq_crystal_a: assert property (wdt_irq |-> $past(crystal_in_pin, 2) ||
    $past(crystal_in_pin, 3) || $past(crystal_in_pin, 4))
    else $error("interrupt without crystal edge");
  reset_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request too long");
endmodule

bind wdl_top wdl_top_monitor i_wdl_top_monitor (.*);

// ==== bench/wdl_top_test.sv ====
// testbench: register, lock and timeout checks of the watchdog top
module wdl_top_test
  import wdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] CTRL = 16'h0300;
  localparam logic [15:0] KEYA = 16'h02EC;
  localparam logic [15:0] PROT = 16'hFFE8;

  logic        core_clk, rst_n, crystal_in_pin, xen;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sys_reset_req, download_reset_req, wdt_irq;
  logic [7:0]  m;
  bit          lk;
  int          errors, checks, seed, cyc, ph, rises, n_sys, n_dl, n_irq, p, e0;

  wdl_top i_wdl_top (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ==========================================================
  // crystal source, event counters, hang guard
  always @(posedge core_clk) begin
    if (xen) begin
      ph <= (ph == 2) ? 0 : ph + 1;
      if (ph == 2) begin
        crystal_in_pin <= ~crystal_in_pin;
        if (!crystal_in_pin) rises <= rises + 1;
      end
    end
    n_sys <= n_sys + int'(sys_reset_req);
    n_dl  <= n_dl + int'(download_reset_req);
    n_irq <= n_irq + int'(wdt_irq);
    cyc++;
    if (cyc > 40000) begin
      errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // bus master: hold each channel until its own ready
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // pair kept back to back
  // unlock then write; model keeps what a locked part forces
  task pair(input logic [7:0] d);
    wr(CTRL, 32'h1, WDL_RESP_OKAY);
    wr(CTRL, {24'h0, d}, WDL_RESP_OKAY);
    m = d & 8'hFA;
    if (lk) m = (m & 8'hF0) | 8'h02;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {rst_n, crystal_in_pin, xen, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {errors, checks, cyc, ph, rises, n_sys, n_dl, n_irq} = '0;
    seed = 32'h17AA5FF3;
    lk = 1'b0;
    m = 8'h72;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CTRL, 32'h72, WDL_RESP_OKAY);
    wr(CTRL, 32'h02, WDL_RESP_OKAY);
    rd(CTRL, 32'h72, WDL_RESP_OKAY);
    wr(CTRL, 32'h1, WDL_RESP_OKAY);
    wr(KEYA, 32'hFF, WDL_RESP_OKAY);
    wr(CTRL, 32'h02, WDL_RESP_OKAY);
    rd(CTRL, 32'h72, WDL_RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      p = $random(seed) & 1;
      pair(8'(p << 4) | 8'(i << 3) | 8'h02);
      e0 = rises;
      xen <= 1'b1;
      do @(posedge core_clk); while (sys_reset_req !== 1'b1 && wdt_irq !== 1'b1);
      xen <= 1'b0;
      chk(32'(rises - e0), 32'(1 << (p + 9)));
      chk(32'(wdt_irq), 32'(i));
      m = m | 8'h04;
      rd(CTRL, {24'h0, m}, WDL_RESP_OKAY);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(CTRL, 32'h72, WDL_RESP_OKAY);
    wr(16'h0320, 32'h55, WDL_RESP_OKAY);
    rd(16'h0320, 32'h0, WDL_RESP_OKAY);
    wr(KEYA, 32'hFF, WDL_RESP_OKAY);
    pair(8'h00);
    e0 = n_sys + n_irq;
    xen <= 1'b1;
    repeat (4000) @(posedge core_clk);
    xen <= 1'b0;
    chk(32'(n_sys + n_irq - e0), 32'h0);
    rd(CTRL, {24'h0, m}, WDL_RESP_OKAY);
    e0 = n_sys;
    pair(8'h82);
    repeat (3) @(posedge core_clk);
    chk(32'(n_sys - e0), 32'h1);
    e0 = n_dl;
    pair(8'h92);
    repeat (3) @(posedge core_clk);
    chk(32'(n_dl - e0), 32'h1);
    rd(16'h0301, 32'h0, WDL_RESP_DECERR);
    wr(16'h0004, 32'h55, WDL_RESP_DECERR);
    rd(CTRL, {24'h0, m}, WDL_RESP_OKAY);
    pair(8'h38);
    wr(PROT, 32'h7F, WDL_RESP_OKAY);
    lk = 1'b1;
    m = (m & 8'hF0) | 8'h02;
    rd(CTRL, {24'h0, m}, WDL_RESP_OKAY);
    pair(8'h58);
    rd(CTRL, {24'h0, m}, WDL_RESP_OKAY);
    wr(PROT, 32'hFF, WDL_RESP_SLVERR);
    rd(PROT, 32'h7F, WDL_RESP_OKAY);
    wr(KEYA, 32'h7F, WDL_RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(KEYA, 32'h11, WDL_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(KEYA, 32'h7F, WDL_RESP_OKAY);
    wr(16'hFFEC, 32'h00, WDL_RESP_OKAY);
    rd(16'hFFEC, 32'h00, WDL_RESP_OKAY);
    report_and_stop();
  end
endmodule
